// ---- cic_can_irq.v ----
// interrupt flags, request pulse and register slave of a can 2.0 controller
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "cic_defines.vh"

module cic_can_irq #(
  parameter RX_DEPTH = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire frame_done,
  input wire frame_err,
  input wire frame_own,
  input wire tx_done,
  input wire bus_error,
  input wire arb_lost,
  input wire bit_tick,
  input wire err_warn,
  input wire [7:0] tx_err_cnt,
  input wire [7:0] rx_err_cnt,
  output reg can_irq_pulse,
  output reg irq,
  output reg rx_mode,
  output reg can_reset_n
);

  // ****************************************
  // helpers
  // ****************************************
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  localparam [7:0] DEPTH = RX_DEPTH;
  localparam [3:0] RECOV_BITS = `CIC_ERR_DOM_BITS + `CIC_ERR_DELIM_BITS;

  // ****************************************
  // state
  // ****************************************
  reg ctrl_en_ff;
  reg [7:0] ien_ff;
  reg [7:0] mask_ff;
  reg [7:0] flags_ff;
  reg [7:0] evt_ff;
  reg [7:0] rmc_ff;
  reg rmc_inc_ff;
  reg prev_zero_ff;
  reg [3:0] recov_cnt_ff;
  reg passive_ff;
  reg warn_ff;
  reg [7:0] nxt_flags;
  reg [7:0] nxt_evt;
  reg [7:0] nxt_rmc;
  reg [7:0] ev;
  reg [31:0] nxt_rdata;
  reg nxt_err;

  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire recovering = (recov_cnt_ff != 4'h0);
  wire passive_now = (tx_err_cnt > `CIC_EP_LIMIT) | (rx_err_cnt > `CIC_EP_LIMIT);
  wire release_receive_buffer = wr & hit(paddr, `CIC_CMD_OFF) & pwdata[`CIC_CMD_RRB_BIT];
  wire rrb_eff = release_receive_buffer & (rmc_ff != 8'h00);
  // valid frames only: no error, not our own, not during error recovery
  wire accept = frame_done & ~frame_err & ~frame_own & ~recovering;
  wire room = (rmc_ff != DEPTH) | rrb_eff;
  wire store = accept & room;
  wire overrun = accept & ~room;

  // ****************************************
  // event decode
  // ****************************************
  always @* begin
    ev = 8'h00;
    ev[`CIC_BE_BIT] = bus_error;
    ev[`CIC_AL_BIT] = arb_lost;
    ev[`CIC_EP_BIT] = passive_now & ~passive_ff;
    ev[`CIC_DO_BIT] = overrun;
    ev[`CIC_EW_BIT] = err_warn & ~warn_ff;
    ev[`CIC_TI_BIT] = tx_done;
    ev[`CIC_RI_BIT] = rmc_inc_ff;
  end

  // ****************************************
  // next flag, status and counter values
  // ****************************************
  always @* begin
    nxt_flags = flags_ff;
    // a read clears only the bits it returned, so a flag set after the
    // data was latched is not lost; receive is never cleared by a read
    if (rd & hit(paddr, `CIC_FLAGS_OFF)) begin
      nxt_flags = flags_ff & ~(prdata[7:0] & ~8'h01);
    end
    if (release_receive_buffer) begin
      nxt_flags[`CIC_RI_BIT] = 1'b0;
    end
    // sets win over clears
    nxt_flags = nxt_flags | (ev & ien_ff & `CIC_FLAG_MASK);
    nxt_evt = evt_ff;
    if (wr & hit(paddr, `CIC_EVT_OFF)) begin
      nxt_evt = evt_ff & ~pwdata[7:0];
    end
    nxt_evt = nxt_evt | (ev & `CIC_FLAG_MASK);
    nxt_rmc = rmc_ff;
    if (store & ~rrb_eff) begin
      nxt_rmc = rmc_ff + 8'h01;
    end else if (~store & rrb_eff) begin
      nxt_rmc = rmc_ff - 8'h01;
    end
  end

  // ****************************************
  // read data decode
  // ****************************************
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_err = 1'b0;
    case (paddr)
      `CIC_CTRL_OFF: nxt_rdata[0] = ctrl_en_ff;
      `CIC_CMD_OFF: nxt_rdata = 32'h00000000;
      `CIC_FLAGS_OFF: nxt_rdata[7:0] = flags_ff;
      `CIC_IEN_OFF: nxt_rdata[7:0] = ien_ff;
      `CIC_RMC_OFF: nxt_rdata[7:0] = rmc_ff;
      `CIC_EVT_OFF: nxt_rdata[7:0] = evt_ff;
      `CIC_MASK_OFF: nxt_rdata[7:0] = mask_ff;
      `CIC_STATE_OFF: begin
        nxt_rdata[`CIC_ST_RXMODE_BIT] = rx_mode;
        nxt_rdata[`CIC_ST_RECOV_BIT] = recovering;
        nxt_rdata[`CIC_ST_PASSIVE_BIT] = passive_ff;
        nxt_rdata[`CIC_ST_WARN_BIT] = warn_ff;
      end
      default: nxt_err = 1'b1;
    endcase
  end

  // ****************************************
  // apb slave: one wait-free access phase
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : nxt_rdata;
        pslverr <= nxt_err;
      end else if (access) begin
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_ff <= `CIC_CTRL_RST;
      ien_ff <= `CIC_IEN_RST;
      mask_ff <= `CIC_MASK_RST;
    end else if (wr) begin
      if (hit(paddr, `CIC_CTRL_OFF)) begin
        ctrl_en_ff <= pwdata[`CIC_CTRL_EN_BIT];
      end
      if (hit(paddr, `CIC_IEN_OFF)) begin
        ien_ff <= pwdata[7:0] & `CIC_FLAG_MASK;
      end
      if (hit(paddr, `CIC_MASK_OFF)) begin
        mask_ff <= pwdata[7:0] & `CIC_FLAG_MASK;
      end
    end
  end

  // ****************************************
  // flags, counter and line state
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= `CIC_FLAGS_RST;
      evt_ff <= 8'h00;
      rmc_ff <= 8'h00;
      rmc_inc_ff <= 1'b0;
      recov_cnt_ff <= 4'h0;
      passive_ff <= 1'b0;
      warn_ff <= 1'b0;
      rx_mode <= 1'b0;
      can_reset_n <= 1'b0;
    end else if (!ctrl_en_ff) begin
      // disabled: everything but the event status held in reset, fifo contents dropped
      flags_ff <= `CIC_FLAGS_RST;
      evt_ff <= nxt_evt;
      rmc_ff <= 8'h00;
      rmc_inc_ff <= 1'b0;
      recov_cnt_ff <= 4'h0;
      passive_ff <= 1'b0;
      warn_ff <= 1'b0;
      rx_mode <= 1'b0;
      can_reset_n <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      evt_ff <= nxt_evt;
      rmc_ff <= nxt_rmc;
      // receive flag follows a counter increase by one cycle
      rmc_inc_ff <= store & ~rrb_eff & ~flags_ff[`CIC_RI_BIT];
      passive_ff <= passive_now;
      warn_ff <= err_warn;
      can_reset_n <= 1'b1;
      if (bus_error) begin
        recov_cnt_ff <= RECOV_BITS;
      end else if (recovering & bit_tick) begin
        recov_cnt_ff <= recov_cnt_ff - 4'h1;
      end
      if (arb_lost) begin
        rx_mode <= 1'b1;
      end else if (frame_done | bus_error) begin
        rx_mode <= 1'b0;
      end
    end
  end

  // ****************************************
  // request pulse and level interrupt
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_zero_ff <= 1'b1;
      can_irq_pulse <= 1'b0;
      irq <= 1'b0;
    end else begin
      prev_zero_ff <= (flags_ff == 8'h00);
      can_irq_pulse <= prev_zero_ff & (flags_ff != 8'h00);
      irq <= |(evt_ff & mask_ff);
    end
  end

endmodule
`default_nettype wire

// ---- cic_defines.vh ----
// register map, field positions and timing counts of the can interrupt combiner
`ifndef CIC_DEFINES_VH
`define CIC_DEFINES_VH

// register byte offsets
`define CIC_CTRL_OFF 8'h00
`define CIC_CMD_OFF 8'h04
`define CIC_FLAGS_OFF 8'h08
`define CIC_IEN_OFF 8'h0c
`define CIC_RMC_OFF 8'h10
`define CIC_EVT_OFF 8'h14
`define CIC_MASK_OFF 8'h18
`define CIC_STATE_OFF 8'h1c

// interrupt flag bit positions (shared by flags, enable, status and mask)
`define CIC_BE_BIT 7
`define CIC_AL_BIT 6
`define CIC_EP_BIT 5
`define CIC_DO_BIT 3
`define CIC_EW_BIT 2
`define CIC_TI_BIT 1
`define CIC_RI_BIT 0

// control and command bits
`define CIC_CTRL_EN_BIT 0
`define CIC_CMD_RRB_BIT 2

// state register bits
`define CIC_ST_RXMODE_BIT 0
`define CIC_ST_RECOV_BIT 1
`define CIC_ST_PASSIVE_BIT 2
`define CIC_ST_WARN_BIT 3

// reset values
`define CIC_FLAGS_RST 8'h00
`define CIC_IEN_RST 8'h00
`define CIC_MASK_RST 8'h00
`define CIC_CTRL_RST 1'b0

// valid flag bits of the flag register
`define CIC_FLAG_MASK 8'hef

// error signalling after a bus error, in bit times
`define CIC_ERR_DOM_BITS 6
`define CIC_ERR_DELIM_BITS 8

// error counter limit for the error passive state
`define CIC_EP_LIMIT 8'h7f

`endif

// ---- cic_chk.sv ----
// port assertions of the can interrupt combiner
`timescale 1ns/100ps
`default_nettype none
module cic_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic can_irq_pulse,
  input wire logic can_reset_n
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pulse; can_irq_pulse |=> !can_irq_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse longer than one cycle");
  property p_off; !can_reset_n [*3] |-> !can_irq_pulse; endproperty
  a_off: assert property (p_off) else $error("pulse while disabled");
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready held");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error answer");
  property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  a_idle: assert property (p_idle) else $error("data outside access");
  property p_gap; can_irq_pulse |-> $past(can_reset_n); endproperty
  a_gap: assert property (p_gap) else $error("pulse without enabled core");
endmodule
bind cic_can_irq cic_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .can_irq_pulse(can_irq_pulse), .can_reset_n(can_reset_n));
`default_nettype wire

// ---- cic_irq_model.sv ----
// processor side model that counts request pulses
`timescale 1ns/100ps
`default_nettype none
module cic_irq_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic can_irq_pulse,
  output logic [7:0] pend_cnt
);
  // ****
  // pending counter
  // ****
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_cnt <= 8'h00;
    end else if (can_irq_pulse) begin
      pend_cnt <= pend_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// self-checking testbench of the can interrupt combiner
`timescale 1ns/100ps
`default_nettype none
`include "cic_defines.vh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, er, f_err, f_own, warn, pready, pslverr, pul, irq;
  logic tick, rxm;
  logic [7:0] paddr, txc, pc;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] p;
  int fail_count, check_count;
  // ****
  // design and processor model
  // ****
  cic_can_irq dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_done(p[0]), .frame_err(f_err), .frame_own(f_own),
    .tx_done(p[1]), .bus_error(p[2]), .arb_lost(p[3]), .bit_tick(tick), .err_warn(warn),
    .tx_err_cnt(txc), .rx_err_cnt(8'h00), .can_irq_pulse(pul), .irq(irq), .rx_mode(rxm),
    .can_reset_n());
  cic_irq_model u_cpu (.pclk(pclk), .presetn(presetn), .can_irq_pulse(pul), .pend_cnt(pc));
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      finish_test;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask
  task ev(input logic [3:0] v);
    p <= v;
    @(posedge pclk);
    p <= 4'h0;
    repeat (4) @(posedge pclk);
  endtask
  // ****
  // scenarios
  // ****
  task t_tx;
    ev(4'h2);
    rdc(`CIC_FLAGS_OFF, 32'h02, "tx flag");
    chk("pulses", 32'h1, {24'h0, pc});
    rdc(`CIC_FLAGS_OFF, 32'h00, "flags cleared");
    $display("t_tx done");
  endtask
  task t_rx;
    ev(4'h1);
    rdc(`CIC_RMC_OFF, 32'h01, "counter");
    rdc(`CIC_FLAGS_OFF, 32'h01, "rx flag");
    rdc(`CIC_FLAGS_OFF, 32'h01, "rx kept");
    chk("pulses", 32'h2, {24'h0, pc});
    apb(1'b1, `CIC_CMD_OFF, 32'h4);
    rdc(`CIC_FLAGS_OFF, 32'h00, "rx released");
    ev(4'h8);
    chk("rx mode", 32'h1, {31'h0, rxm});
    ev(4'h1);
    chk("pulses", 32'h3, {24'h0, pc});
    rdc(`CIC_FLAGS_OFF, 32'h41, "arb flag");
    apb(1'b1, `CIC_CMD_OFF, 32'h4);
    $display("t_rx done");
  endtask
  task t_rej;
    f_own <= 1'b1;
    ev(4'h1);
    f_own <= 1'b0;
    f_err <= 1'b1;
    ev(4'h1);
    f_err <= 1'b0;
    rdc(`CIC_RMC_OFF, 32'h00, "rejected");
    repeat (9) ev(4'h1);
    rdc(`CIC_FLAGS_OFF, 32'h09, "overrun");
    apb(1'b1, `CIC_CTRL_OFF, 32'h0);
    apb(1'b1, `CIC_CTRL_OFF, 32'h1);
    rdc(`CIC_RMC_OFF, 32'h00, "counter reset");
    $display("t_rej done");
  endtask
  task t_err;
    txc <= 8'h7f;
    ev(4'h0);
    rdc(`CIC_FLAGS_OFF, 32'h00, "no passive");
    txc <= 8'h80;
    warn <= 1'b1;
    ev(4'h0);
    rdc(`CIC_FLAGS_OFF, 32'h24, "passive warn");
    ev(4'h1);
    ev(4'h4);
    ev(4'h1);
    rdc(`CIC_FLAGS_OFF, 32'h81, "bus error");
    rdc(`CIC_RMC_OFF, 32'h01, "blocked");
    apb(1'b1, `CIC_CMD_OFF, 32'h4);
    tick <= 1'b1;
    repeat (13) @(posedge pclk);
    tick <= 1'b0;
    ev(4'h1);
    rdc(`CIC_RMC_OFF, 32'h00, "still recovering");
    tick <= 1'b1;
    @(posedge pclk);
    tick <= 1'b0;
    ev(4'h1);
    rdc(`CIC_RMC_OFF, 32'h01, "recovered");
    apb(1'b1, `CIC_CMD_OFF, 32'h4);
    $display("t_err done");
  endtask
  task t_irq;
    apb(1'b1, `CIC_EVT_OFF, 32'hff);
    apb(1'b1, `CIC_MASK_OFF, 32'h02);
    ev(4'h2);
    chk("irq set", 32'h1, {31'h0, irq});
    apb(1'b1, `CIC_EVT_OFF, 32'h02);
    ev(4'h0);
    chk("irq clear", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    $display("t_irq done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, f_err, f_own, warn, tick} = 8'h0;
    {paddr, txc, pwdata, p} = 52'h0;
    fail_count = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `CIC_CTRL_OFF, 32'h1);
    apb(1'b1, `CIC_IEN_OFF, 32'hef);
    t_tx;
    t_rx;
    t_rej;
    t_err;
    t_irq;
    finish_test;
  end
endmodule
`default_nettype wire
